// *** core/probe_channel.sv ***
// one touch probe: edge detection, position capture and edge counters
`default_nettype none
module probe_channel (
  input  wire logic        clock,
  input  wire logic        rst_b,
  input  wire logic        trigger_di,
  input  wire logic        encoder_z,
  input  wire logic [31:0] position,
  probe_channel_if.channel port
);
  logic prev_level;
  logic was_enabled;
  logic armed;
  // ==========================================================================
  // edge qualification; the first enabled cycle only samples, so a level
  // already high at enable is not taken as an edge
  wire level    = port.source_z ? encoder_z : trigger_di;
  wire start    = port.enable & ~was_enabled;
  wire live     = port.enable & ~start & (armed | port.continuous);
  wire rise_hit = live & port.rise_en & level & ~prev_level;
  wire fall_hit = live & port.fall_en & ~level & prev_level;
  wire any_hit  = rise_hit | fall_hit;

  // history of the trigger level and of the enable
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      prev_level  <= 1'b0;
      was_enabled <= 1'b0;
    end else begin
      prev_level  <= level;
      was_enabled <= port.enable;
    end
  end

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      armed <= 1'b0;
    end else if (start) begin
      armed <= 1'b1;
    end else if (!port.enable || (any_hit && !port.continuous)) begin
      armed <= 1'b0;
    end
  end

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      port.rise_pos <= 32'h0000_0000;
      port.fall_pos <= 32'h0000_0000;
    end else begin
      if (rise_hit) port.rise_pos <= position;
      if (fall_hit) port.fall_pos <= position;
    end
  end

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      port.rise_cnt <= 16'h0000;
      port.fall_cnt <= 16'h0000;
    end else begin
      if (rise_hit) port.rise_cnt <= port.rise_cnt + 16'h0001;
      if (fall_hit) port.fall_cnt <= port.fall_cnt + 16'h0001;
    end
  end

  // latched flags and continuous event count, cleared on disable
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      port.rise_latched <= 1'b0;
      port.fall_latched <= 1'b0;
      port.event_cnt    <= 2'h0;
    end else if (!port.enable) begin
      port.rise_latched <= 1'b0;
      port.fall_latched <= 1'b0;
      port.event_cnt    <= 2'h0;
    end else begin
      if (rise_hit) port.rise_latched <= 1'b1;
      if (fall_hit) port.fall_latched <= 1'b1;
      if (any_hit && port.continuous) port.event_cnt <= port.event_cnt + 2'h1;
    end
  end

  // single mode takes no further edge once one was taken
  chk_single_one_shot: assert property (@(posedge clock) disable iff (!rst_b)
    (any_hit && !port.continuous && port.enable) ##1 (port.enable && !port.continuous)
      |-> !any_hit)
    else $error("single mode took a second edge");
endmodule
`default_nettype wire

// *** core/touch_probe_capture_io.sv ***
// touch probe position capture, input status and forced output word
`default_nettype none
// Behaviour
// - Probe one rising edge latches position feedback into its rise register.
// - Probe one falling edge latches position feedback into its fall register.
// - Probe two rising edge latches position feedback into its rise register.
// - Probe two falling edge latches position into its fall register, reset zero.
// - Four 16-bit edge counters start at zero and count each capture.
// - Input status word: bit0 reverse, bit1 forward overtravel, bit2 home.
// - General inputs on bits 16-20, safety 27-28, monitor 29, Z 30.
// - Mask bit 16 set: output one follows output word bit 16.
// - Mask bit 17 set: output two follows output word bit 17.
// - Mask bit 26 set: output word bit 26 picks P or PI gain.
// - Status flags show latched rise/fall values and mirror each probe enable.
// - Continuous mode reports a two-bit event count in status bits 6-7, 14-15.
module touch_probe_capture_io (
  input  wire logic        clock,
  input  wire logic        rst_b,
  input  wire logic [15:0] reg_addr,
  input  wire logic        reg_write,
  input  wire logic        reg_read,
  input  wire logic [31:0] reg_wdata,
  output logic      [31:0] reg_rdata,
  output logic             reg_ack,
  output logic             reg_error,
  input  wire logic [31:0] position_feedback,
  input  wire logic        reverse_overtravel,
  input  wire logic        forward_overtravel,
  input  wire logic        home_switch,
  input  wire logic [4:0]  general_input,
  input  wire logic        safe_torque_off_input_a,
  input  wire logic        safe_torque_off_input_b,
  input  wire logic        external_device_monitor,
  input  wire logic        encoder_z,
  input  wire logic        normal_output_one,
  input  wire logic        normal_output_two,
  input  wire logic        normal_gain_integral,
  output logic             digital_output_one,
  output logic             digital_output_two,
  output logic             gain_integral_select
);
  logic [15:0] probe_control_word;
  logic [31:0] forced_output_word;
  logic [31:0] output_mask_word;
  logic [31:0] input_status_word;
  logic [31:0] next_rdata;

  probe_channel_if one ();
  probe_channel_if two ();

  // ==========================================================================
  // probe configuration fan-out
  localparam int B2 = touch_probe_pkg::PROBE_TWO_BASE;
  assign one.enable     = probe_control_word[touch_probe_pkg::CTL_ENABLE];
  assign one.continuous = probe_control_word[touch_probe_pkg::CTL_CONTINUOUS];
  assign one.source_z   = probe_control_word[touch_probe_pkg::CTL_SOURCE_Z];
  assign one.rise_en    = probe_control_word[touch_probe_pkg::CTL_RISE_EN];
  assign one.fall_en    = probe_control_word[touch_probe_pkg::CTL_FALL_EN];
  assign two.enable     = probe_control_word[B2 + touch_probe_pkg::CTL_ENABLE];
  assign two.continuous = probe_control_word[B2 + touch_probe_pkg::CTL_CONTINUOUS];
  assign two.source_z   = probe_control_word[B2 + touch_probe_pkg::CTL_SOURCE_Z];
  assign two.rise_en    = probe_control_word[B2 + touch_probe_pkg::CTL_RISE_EN];
  assign two.fall_en    = probe_control_word[B2 + touch_probe_pkg::CTL_FALL_EN];

  probe_channel probe_one (
    .clock      (clock),
    .rst_b      (rst_b),
    .trigger_di (general_input[touch_probe_pkg::PROBE_ONE_DI]),
    .encoder_z  (encoder_z),
    .position   (position_feedback),
    .port       (one.channel)
  );

  probe_channel probe_two (
    .clock      (clock),
    .rst_b      (rst_b),
    .trigger_di (general_input[touch_probe_pkg::PROBE_TWO_DI]),
    .encoder_z  (encoder_z),
    .position   (position_feedback),
    .port       (two.channel)
  );

  // ==========================================================================
  // probe status word; unused bits stay zero
  // latched flags, enable mirror and event counts
  wire [15:0] probe_status_word = {two.event_cnt, 3'h0, two.fall_latched,
                                   two.rise_latched, two.enable,
                                   one.event_cnt, 3'h0, one.fall_latched,
                                   one.rise_latched, one.enable};

  // live input bits, undefined bits read zero
  wire [31:0] next_inputs = {1'b0, encoder_z, external_device_monitor,
                             safe_torque_off_input_b, safe_torque_off_input_a,
                             6'h00, general_input, 13'h0000, home_switch,
                             forward_overtravel, reverse_overtravel};

  // registered input image so the read value is one coherent snapshot
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) input_status_word <= touch_probe_pkg::RST_WORD;
    else        input_status_word <= next_inputs;
  end

  // ==========================================================================
  // register port: writes take effect at once, reads answer next cycle
  wire wr_control = reg_write && (reg_addr == touch_probe_pkg::OFS_CONTROL);
  wire wr_forced  = reg_write && (reg_addr == touch_probe_pkg::OFS_FORCED_OUT);
  wire wr_mask    = reg_write && (reg_addr == touch_probe_pkg::OFS_OUTPUT_MASK);

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      probe_control_word <= touch_probe_pkg::RST_CONTROL;
      forced_output_word <= touch_probe_pkg::RST_WORD;
      output_mask_word   <= touch_probe_pkg::RST_WORD;
    end else begin
      if (wr_control) probe_control_word <= reg_wdata[15:0];
      if (wr_forced)  forced_output_word <= reg_wdata;
      if (wr_mask)    output_mask_word   <= reg_wdata;
    end
  end

  // read select; an unmapped address reads zero and flags an error
  logic hit;
  always_comb begin
    hit        = 1'b1;
    next_rdata = 32'h0000_0000;
    unique case (reg_addr)
      touch_probe_pkg::OFS_ONE_RISE_POS: next_rdata = one.rise_pos;
      touch_probe_pkg::OFS_ONE_FALL_POS: next_rdata = one.fall_pos;
      touch_probe_pkg::OFS_TWO_RISE_POS: next_rdata = two.rise_pos;
      touch_probe_pkg::OFS_TWO_FALL_POS: next_rdata = two.fall_pos;
      touch_probe_pkg::OFS_CONTROL:      next_rdata = {16'h0000, probe_control_word};
      touch_probe_pkg::OFS_STATUS:       next_rdata = {16'h0000, probe_status_word};
      touch_probe_pkg::OFS_ONE_RISE_CNT: next_rdata = {16'h0000, one.rise_cnt};
      touch_probe_pkg::OFS_ONE_FALL_CNT: next_rdata = {16'h0000, one.fall_cnt};
      touch_probe_pkg::OFS_TWO_RISE_CNT: next_rdata = {16'h0000, two.rise_cnt};
      touch_probe_pkg::OFS_TWO_FALL_CNT: next_rdata = {16'h0000, two.fall_cnt};
      touch_probe_pkg::OFS_INPUT_STATUS: next_rdata = input_status_word;
      touch_probe_pkg::OFS_FORCED_OUT:   next_rdata = forced_output_word;
      touch_probe_pkg::OFS_OUTPUT_MASK:  next_rdata = output_mask_word;
      default:                           hit = 1'b0;
    endcase
  end

  // answer flops; writes to read-only objects are acknowledged and dropped
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      reg_rdata <= 32'h0000_0000;
      reg_ack   <= 1'b0;
      reg_error <= 1'b0;
    end else begin
      reg_ack   <= reg_read | reg_write;
      reg_error <= (reg_read | reg_write) & ~hit;
      if (reg_read) reg_rdata <= next_rdata;
    end
  end

  // ==========================================================================
  // outputs: the mask hands each one over from the drive to the output word
  wire next_out_one = output_mask_word[touch_probe_pkg::OUT_ONE] ?
                      forced_output_word[touch_probe_pkg::OUT_ONE] : normal_output_one;
  wire next_out_two = output_mask_word[touch_probe_pkg::OUT_TWO] ?
                      forced_output_word[touch_probe_pkg::OUT_TWO] : normal_output_two;
  wire next_gain    = output_mask_word[touch_probe_pkg::OUT_GAIN] ?
                      forced_output_word[touch_probe_pkg::OUT_GAIN] : normal_gain_integral;

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      digital_output_one   <= 1'b0;
      digital_output_two   <= 1'b0;
      gain_integral_select <= 1'b0;
    end else begin
      digital_output_one   <= next_out_one;
      digital_output_two   <= next_out_two;
      gain_integral_select <= next_gain;
    end
  end

  // ==========================================================================
  // checks
  chk_one_rise_capture: assert property (@(posedge clock) disable iff (!rst_b)
    (one.rise_cnt != $past(one.rise_cnt)) |-> one.rise_pos == $past(position_feedback))
    else $error("probe one rise position not the feedback at the edge");
  chk_one_fall_capture: assert property (@(posedge clock) disable iff (!rst_b)
    (one.fall_cnt != $past(one.fall_cnt)) |-> one.fall_pos == $past(position_feedback))
    else $error("probe one fall position not the feedback at the edge");
  chk_two_rise_capture: assert property (@(posedge clock) disable iff (!rst_b)
    (two.rise_cnt != $past(two.rise_cnt)) |-> two.rise_pos == $past(position_feedback))
    else $error("probe two rise position not the feedback at the edge");
  chk_two_fall_capture: assert property (@(posedge clock) disable iff (!rst_b)
    $changed(two.fall_pos) |-> two.fall_cnt == $past(two.fall_cnt) + 16'h0001)
    else $error("probe two fall position moved without a counted edge");
  chk_counter_wrap_step: assert property (@(posedge clock) disable iff (!rst_b)
    $changed(one.rise_cnt) |-> one.rise_cnt == $past(one.rise_cnt) + 16'h0001)
    else $error("probe one rise counter did not step by one");
  chk_input_low_bits: assert property (@(posedge clock) disable iff (!rst_b)
    ##1 input_status_word[2:0] ==
        $past({home_switch, forward_overtravel, reverse_overtravel}))
    else $error("overtravel or home bit wrong");
  chk_input_high_bits: assert property (@(posedge clock) disable iff (!rst_b)
    ##1 (input_status_word[20:16] == $past(general_input)) &&
        input_status_word[30] == $past(encoder_z) &&
        input_status_word[31] == 1'b0 && input_status_word[26:21] == 6'h00)
    else $error("input status word upper bits wrong");
  chk_forced_out_one: assert property (@(posedge clock) disable iff (!rst_b)
    (output_mask_word[16] && $stable(output_mask_word) && $stable(forced_output_word))
      |=> digital_output_one == $past(forced_output_word[16]))
    else $error("output one not following the forced word");
  chk_forced_out_two: assert property (@(posedge clock) disable iff (!rst_b)
    output_mask_word[17] |=> digital_output_two == $past(forced_output_word[17]))
    else $error("output two not following the forced word");
  chk_gain_select: assert property (@(posedge clock) disable iff (!rst_b)
    !output_mask_word[26] |=> gain_integral_select == $past(normal_gain_integral))
    else $error("gain select forced while its mask bit is clear");
  chk_latched_flag: assert property (@(posedge clock) disable iff (!rst_b)
    $changed(two.rise_cnt) |-> probe_status_word[B2 + touch_probe_pkg::STS_RISE])
    else $error("probe two rise flag not set after capture");
  chk_event_count: assert property (@(posedge clock) disable iff (!rst_b)
    !one.enable |=> probe_status_word[7:6] == 2'h0 || one.enable)
    else $error("probe one event count not cleared when disabled");
endmodule
`default_nettype wire

// *** pkg/probe_channel_if.sv ***
// configuration and results passed between the top and one probe channel
`default_nettype none
interface probe_channel_if;
  logic        enable;
  logic        continuous;
  logic        source_z;
  logic        rise_en;
  logic        fall_en;
  logic [31:0] rise_pos;
  logic [31:0] fall_pos;
  logic [15:0] rise_cnt;
  logic [15:0] fall_cnt;
  logic        rise_latched;
  logic        fall_latched;
  logic [1:0]  event_cnt;
  modport top (output enable, continuous, source_z, rise_en, fall_en,
               input rise_pos, fall_pos, rise_cnt, fall_cnt, rise_latched,
               fall_latched, event_cnt);
  modport channel (input enable, continuous, source_z, rise_en, fall_en,
                   output rise_pos, fall_pos, rise_cnt, fall_cnt, rise_latched,
                   fall_latched, event_cnt);
endinterface
`default_nettype wire

// *** pkg/touch_probe_pkg.sv ***
// constants shared by the touch probe capture and digital i/o block
`default_nettype none
package touch_probe_pkg;
  // ==========================================================================
  // register offsets (object addresses)
  localparam logic [15:0] OFS_ONE_RISE_POS = 16'h35f4;
  localparam logic [15:0] OFS_ONE_FALL_POS = 16'h35f8;
  localparam logic [15:0] OFS_TWO_RISE_POS = 16'h35fa;
  localparam logic [15:0] OFS_TWO_FALL_POS = 16'h35fc;
  localparam logic [15:0] OFS_CONTROL      = 16'h35f0;
  localparam logic [15:0] OFS_STATUS       = 16'h35f2;
  localparam logic [15:0] OFS_ONE_RISE_CNT = 16'h362c;
  localparam logic [15:0] OFS_ONE_FALL_CNT = 16'h362e;
  localparam logic [15:0] OFS_TWO_RISE_CNT = 16'h3630;
  localparam logic [15:0] OFS_TWO_FALL_CNT = 16'h3632;
  localparam logic [15:0] OFS_INPUT_STATUS = 16'h367c;
  localparam logic [15:0] OFS_FORCED_OUT   = 16'h3781;
  localparam logic [15:0] OFS_OUTPUT_MASK  = 16'h3782;
  // ==========================================================================
  // reset values
  localparam logic [31:0] RST_WORD    = 32'h0000_0000;
  localparam logic [15:0] RST_CONTROL = 16'h0000;
  // ==========================================================================
  // control and status field positions, probe two is offset by PROBE_TWO_BASE
  localparam int PROBE_TWO_BASE = 8;
  localparam int CTL_ENABLE     = 0;
  localparam int CTL_CONTINUOUS = 1;
  localparam int CTL_SOURCE_Z   = 2;
  localparam int CTL_RISE_EN    = 4;
  localparam int CTL_FALL_EN    = 5;
  localparam int STS_ENABLED    = 0;
  localparam int STS_RISE       = 1;
  localparam int STS_FALL       = 2;
  localparam int STS_EVENTS     = 6;
  // ==========================================================================
  // output word bits and input status word bits
  localparam int OUT_ONE  = 16;
  localparam int OUT_TWO  = 17;
  localparam int OUT_GAIN = 26;
  localparam int IN_REV   = 0;
  localparam int IN_FWD   = 1;
  localparam int IN_HOME  = 2;
  localparam int IN_GEN   = 16;
  localparam int IN_STO_A = 27;
  localparam int IN_STO_B = 28;
  localparam int IN_EDM   = 29;
  localparam int IN_Z     = 30;
  // general input index that triggers each probe when the input source is chosen
  localparam int PROBE_ONE_DI = 0;
  localparam int PROBE_TWO_DI = 1;
endpackage
`default_nettype wire

// *** test/host_controller_model.sv ***
// host controller model: object dictionary reads and writes on the register port
`default_nettype none
module host_controller_model (
  input  wire logic        clock,
  output logic      [15:0] reg_addr,
  output logic             reg_write,
  output logic             reg_read,
  output logic      [31:0] reg_wdata,
  input  wire logic [31:0] reg_rdata,
  input  wire logic        reg_ack,
  input  wire logic        reg_error
);
  timeunit 1ns;
  timeprecision 1ns;
  // ==========================================================================
  // idle bus
  initial begin
    reg_addr  = 16'h0000;
    reg_write = 1'b0;
    reg_read  = 1'b0;
    reg_wdata = 32'h0000_0000;
  end
  // ==========================================================================
  // control word layout for one probe, probe two sits eight bits higher
  // enable, mode, source, edge enables
  function automatic logic [15:0] probe_ctl(input int ch, input logic cont, zsrc, rise, fall);
    return 16'({fall, rise, 1'b0, zsrc, cont, 1'b1}) << (ch * 8);
  endfunction
  // one access: a one-cycle request, then a bounded wait for the acknowledge;
  // address and data are inverted afterwards so nothing leans on stale values
  task automatic access(input logic wr, input logic [15:0] addr, input logic [31:0] wdata,
                        output logic [31:0] rdata, output logic err, output logic ok);
    int n;
    n  = 0;
    ok = 1'b0;
    @(negedge clock);
    reg_addr  = addr;
    reg_wdata = wdata;
    reg_write = wr;
    reg_read  = !wr;
    @(negedge clock);
    reg_write = 1'b0;
    reg_read  = 1'b0;
    reg_addr  = ~addr;
    reg_wdata = ~wdata;
    while (!ok && n < 4) begin
      if (reg_ack === 1'b1) ok = 1'b1;
      else @(negedge clock);
      n++;
    end
    rdata = reg_rdata;
    err   = reg_error;
  endtask
endmodule
`default_nettype wire

// *** test/testbench.sv ***
// self-checking bench for the touch probe capture and i/o block
`default_nettype none
module testbench;
  timeunit 1ns;
  timeprecision 1ns;
  logic        clock = 1'b0;
  logic        rst_b = 1'b0;
  logic [15:0] reg_addr;
  logic        reg_write, reg_read, reg_ack, reg_error;
  logic [31:0] reg_wdata, reg_rdata;
  logic [31:0] position_feedback = 32'h0000_0000;
  logic        reverse_overtravel = 1'b0, forward_overtravel = 1'b0, home_switch = 1'b0;
  logic [4:0]  general_input = 5'h00;
  logic        safe_torque_off_input_a = 1'b0, safe_torque_off_input_b = 1'b0;
  logic        external_device_monitor = 1'b0, encoder_z = 1'b0;
  logic        normal_output_one = 1'b0, normal_output_two = 1'b0, normal_gain_integral = 1'b0;
  logic        digital_output_one, digital_output_two, gain_integral_select;
  int          num_errors = 0;
  int          tests_run = 0;
  // 25 MHz clock
  always #20 clock = ~clock;
  touch_probe_capture_io u_touch_probe_capture_io (.clock(clock), .rst_b(rst_b),
    .reg_addr(reg_addr), .reg_write(reg_write), .reg_read(reg_read), .reg_wdata(reg_wdata),
    .reg_rdata(reg_rdata), .reg_ack(reg_ack), .reg_error(reg_error),
    .position_feedback(position_feedback), .reverse_overtravel(reverse_overtravel),
    .forward_overtravel(forward_overtravel), .home_switch(home_switch),
    .general_input(general_input), .safe_torque_off_input_a(safe_torque_off_input_a),
    .safe_torque_off_input_b(safe_torque_off_input_b),
    .external_device_monitor(external_device_monitor), .encoder_z(encoder_z),
    .normal_output_one(normal_output_one), .normal_output_two(normal_output_two),
    .normal_gain_integral(normal_gain_integral), .digital_output_one(digital_output_one),
    .digital_output_two(digital_output_two), .gain_integral_select(gain_integral_select));
  host_controller_model u_host_controller_model (.clock(clock), .reg_addr(reg_addr),
    .reg_write(reg_write), .reg_read(reg_read), .reg_wdata(reg_wdata),
    .reg_rdata(reg_rdata), .reg_ack(reg_ack), .reg_error(reg_error));
  // ==========================================================================
  // shared helpers
  task automatic check(input logic [31:0] got, exp, input string msg);
    tests_run++;
    if (got !== exp) begin
      num_errors++;
      $display("CHECK FAILED at %0t: %s got %h expected %h", $time, msg, got, exp);
    end
  endtask
  task automatic conclude();
    $display("checks %0d mismatches %0d", tests_run, num_errors);
    if (num_errors == 0 && tests_run > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  // masked read, the mask keeps out fields whose reading is left open
  task automatic rd(input logic [15:0] a, input logic [31:0] exp,
                    input logic [31:0] m = 32'hffff_ffff, input logic exp_err = 1'b0);
    logic [31:0] d;
    logic        e, ok;
    u_host_controller_model.access(1'b0, a, 32'h0, d, e, ok);
    check({31'h0, ok & !(e ^ exp_err)}, 32'h1, "read ack or error flag");
    check(d & m, exp, "read data");
  endtask
  task automatic wr(input logic [15:0] a, input logic [31:0] v);
    logic [31:0] d;
    logic        e, ok;
    u_host_controller_model.access(1'b1, a, v, d, e, ok);
    check({31'h0, ok & !e}, 32'h1, "write ack");
  endtask
  // move one trigger source with a known position, then let it settle
  task automatic drive_edge(input int src, input logic v, input logic [31:0] pos);
    @(negedge clock);
    position_feedback = pos;
    if (src == 2) encoder_z = v;
    else general_input[src] = v;
    repeat (3) @(negedge clock);
  endtask
  // ==========================================================================
  // scenarios
  task automatic test_reset_values();
    logic [15:0] addrs[12] = '{16'h35f4, 16'h35f8, 16'h35fa, 16'h35fc, 16'h362c, 16'h362e,
                               16'h3630, 16'h3632, 16'h367c, 16'h3781, 16'h3782, 16'h35f2};
    foreach (addrs[i]) rd(addrs[i], 32'h0);
    rd(16'h3600, 32'h0, 32'hffff_ffff, 1'b1);
    // read-only objects ignore writes
    wr(16'h35f4, 32'h1234_5678);
    rd(16'h35f4, 32'h0);
  endtask
  task automatic test_input_status();
    reverse_overtravel = 1'b1;
    home_switch = 1'b1;
    general_input = 5'b10101;
    safe_torque_off_input_a = 1'b1;
    external_device_monitor = 1'b1;
    rd(16'h367c, 32'h2815_0005);
    reverse_overtravel = 1'b0;
    home_switch = 1'b0;
    general_input = 5'b01010;
    safe_torque_off_input_a = 1'b0;
    external_device_monitor = 1'b0;
    forward_overtravel = 1'b1;
    safe_torque_off_input_b = 1'b1;
    encoder_z = 1'b1;
    rd(16'h367c, 32'h500a_0002);
    forward_overtravel = 1'b0;
    safe_torque_off_input_b = 1'b0;
    encoder_z = 1'b0;
    general_input = 5'h00;
    repeat (2) @(negedge clock);
  endtask
  task automatic test_forced_outputs();
    normal_output_one = 1'b1;
    normal_gain_integral = 1'b1;
    repeat (2) @(negedge clock);
    check({29'h0, digital_output_one, digital_output_two, gain_integral_select}, 32'h5,
          "normal outputs");
    wr(16'h3781, 32'h0002_0000);
    wr(16'h3782, 32'h0403_0000);
    @(negedge clock);
    check({29'h0, digital_output_one, digital_output_two, gain_integral_select}, 32'h2,
          "forced outputs");
    wr(16'h3782, 32'h0001_0000);
    @(negedge clock);
    check({29'h0, digital_output_one, digital_output_two, gain_integral_select}, 32'h1,
          "partly forced");
    rd(16'h3781, 32'h0002_0000);
    rd(16'h3782, 32'h0001_0000);
  endtask
  task automatic test_probe_one_continuous();
    wr(16'h35f0, {16'h0, u_host_controller_model.probe_ctl(0, 1, 0, 1, 1)});
    drive_edge(0, 1'b1, 32'hfff0_0001);
    drive_edge(0, 1'b0, 32'h0000_7f00);
    drive_edge(0, 1'b1, 32'h0000_0123);
    rd(16'h35f4, 32'h0000_0123);
    rd(16'h35f8, 32'h0000_7f00);
    rd(16'h362c, 32'h2);
    rd(16'h362e, 32'h1);
    rd(16'h35f2, 32'h7, 32'h0000_0007);
  endtask
  task automatic test_probe_two_counts();
    wr(16'h35f0, {16'h0, u_host_controller_model.probe_ctl(1, 1, 0, 1, 0)});
    drive_edge(1, 1'b1, 32'h8000_0000);
    drive_edge(1, 1'b0, 32'h0000_0555);
    drive_edge(1, 1'b1, 32'h7fff_fffe);
    drive_edge(1, 1'b0, 32'h0000_0666);
    drive_edge(1, 1'b1, 32'h7fff_ffff);
    rd(16'h35fa, 32'h7fff_ffff);
    rd(16'h3630, 32'h3);
    rd(16'h3632, 32'h0);
    rd(16'h35f2, 32'h0000_c300, 32'h0000_ff00);
    wr(16'h35f0, 32'h0);
    wr(16'h35f0, {16'h0, u_host_controller_model.probe_ctl(1, 1, 0, 0, 1)});
    drive_edge(1, 1'b0, 32'hffff_fff9);
    rd(16'h35fc, 32'hffff_fff9);
    rd(16'h3632, 32'h1);
    rd(16'h35f2, 32'h0000_4500, 32'h0000_ff00);
  endtask
  task automatic test_probe_one_single();
    wr(16'h35f0, 32'h0);
    wr(16'h35f0, {16'h0, u_host_controller_model.probe_ctl(0, 0, 1, 1, 1)});
    drive_edge(2, 1'b1, 32'ha5a5_0001);
    drive_edge(2, 1'b0, 32'h0bad_0002);
    drive_edge(2, 1'b1, 32'h0000_0003);
    rd(16'h35f4, 32'ha5a5_0001);
    rd(16'h35f8, 32'h0000_7f00);
    rd(16'h362c, 32'h3);
    rd(16'h35f2, 32'h3, 32'h0000_00ff);
    // re-arming lets the next edge of either polarity through
    wr(16'h35f0, 32'h0);
    wr(16'h35f0, {16'h0, u_host_controller_model.probe_ctl(0, 0, 1, 1, 1)});
    drive_edge(2, 1'b0, 32'h0000_0044);
    rd(16'h35f8, 32'h0000_0044);
    rd(16'h362e, 32'h2);
  endtask
  // ==========================================================================
  // main sequence and watchdog; the whole run needs well under 1000 cycles
  initial begin
    repeat (3) @(negedge clock);
    rst_b = 1'b1;
    test_reset_values();
    test_input_status();
    test_forced_outputs();
    test_probe_one_continuous();
    test_probe_two_counts();
    test_probe_one_single();
    conclude();
  end
  initial begin
    repeat (5000) @(posedge clock);
    num_errors++;
    conclude();
  end
endmodule
`default_nettype wire
